/* File: logic/refsw_pkg.sv */
package refsw_pkg;
   // ==================================================
   // register indices (word index, byte address = 4 * index)
   localparam logic [9:0]  IDX_CHIP_MODE  = 10'h040;
   localparam logic [9:0]  IDX_RX_CFG_A   = 10'h080;
   localparam logic [9:0]  IDX_RX_CFG_B   = 10'h081;
   localparam logic [9:0]  IDX_SWITCHOVER = 10'h082;
   localparam logic [9:0]  IDX_MON_CFG    = 10'h083;
   localparam logic [9:0]  IDX_REF_STATUS = 10'h021;
   localparam logic [9:0]  IDX_IRQ_STATUS = 10'h0f0;
   localparam logic [9:0]  IDX_IRQ_MASK   = 10'h0f1;
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 32;

   // ==================================================
   // implemented bits per register; the rest read zero
   localparam logic [7:0]  MASK_CHIP_MODE  = 8'h03;
   localparam logic [7:0]  MASK_RX_CFG_A   = 8'h77;
   localparam logic [7:0]  MASK_RX_CFG_B   = 8'h07;
   localparam logic [7:0]  MASK_SWITCHOVER = 8'h0f;
   localparam logic [7:0]  MASK_MON_CFG    = 8'hbf;
   localparam logic [7:0]  MASK_IRQ        = 8'h03;

   // ==================================================
   // reset values
   localparam logic [7:0]  RST_CHIP_MODE  = 8'h02;
   localparam logic [7:0]  RST_RX_CFG_A   = 8'h00;
   localparam logic [7:0]  RST_RX_CFG_B   = 8'h00;
   localparam logic [7:0]  RST_SWITCHOVER = 8'h00;
   localparam logic [7:0]  RST_MON_CFG    = 8'h00;
   localparam logic [7:0]  RST_IRQ        = 8'h00;

   // ==================================================
   // field positions
   localparam int  B_INT_REF_SEL   = 0;
   localparam int  B_CHIP_PD       = 1;
   localparam int  B_PRI_FMT       = 0;
   localparam int  B_PRI_PD        = 2;
   localparam int  B_SEC_FMT       = 4;
   localparam int  B_SEC_PD        = 6;
   localparam int  B_AUX_FMT       = 0;
   localparam int  B_AUX_PD        = 2;
   localparam int  B_SOFT_SEL      = 0;
   localparam int  B_SOFT_EN       = 1;
   localparam int  B_REDUNDANT     = 2;
   localparam int  B_IMMEDIATE     = 3;
   localparam int  B_ERR_WIN       = 0;
   localparam int  B_CARRIER       = 2;
   localparam int  B_MON_8K        = 4;
   localparam int  B_MON_FREQ      = 5;
   localparam int  B_MON_EN        = 7;
   localparam int  B_ACTIVE_REF    = 3;
   localparam int  B_REF_STAT      = 4;
   localparam int  B_EV_SWITCH     = 0;
   localparam int  B_EV_FAULT      = 1;

   // ==================================================
   // encodings
   localparam logic [1:0]  FMT_CMOS     = 2'h0;
   localparam logic [1:0]  FMT_AC_DIFF  = 2'h1;
   localparam logic [1:0]  FMT_XTAL     = 2'h2;
   localparam logic [1:0]  ST_VALID     = 2'h0;
   localparam logic [1:0]  ST_SLOW      = 2'h1;
   localparam logic [1:0]  ST_FAST      = 2'h2;
   localparam logic [1:0]  ST_FAULT     = 2'h3;
   localparam logic [1:0]  ST_AGREE     = 2'h0;
   localparam logic [1:0]  ST_DISAGREE  = 2'h3;
   localparam logic [1:0]  CAR_10M      = 2'h0;
   localparam logic [1:0]  CAR_19M44    = 2'h1;
   localparam logic [1:0]  CAR_25M      = 2'h2;
   localparam logic [1:0]  CAR_38M88    = 2'h3;
   // effective monitor reference code: carrier codes, or 8 kHz
   localparam logic [2:0]  MREF_8K      = 3'h4;
   localparam logic [1:0]  WIN_10PPM    = 2'h0;
   localparam logic [1:0]  WIN_25PPM    = 2'h1;
   localparam logic [1:0]  WIN_50PPM    = 2'h2;
   localparam logic [1:0]  WIN_100PPM   = 2'h3;

   // monitored input frequency: 0 -> 25 MHz, 1 -> 19.44 MHz
   typedef enum logic {MON_25M, MON_19M44} mon_freq_t;
endpackage

/* File: logic/sync_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // async in, synchronised out
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: logic/reference_input_switchover_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module reference_input_switchover_ctrl
   import refsw_pkg::*;
(
   // apb clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output var  logic [DATA_W-1:0] prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // pins and monitor verdicts (asynchronous)
   input  wire logic              ref_sel_pin,
   input  wire logic [1:0]        primary_verdict,
   input  wire logic [1:0]        secondary_verdict,
   // chip control
   output var  logic              chip_power_down,
   output var  logic              integer_loop_ref_aux,
   // input receivers
   output var  logic              primary_pd,
   output var  logic [1:0]        primary_format,
   output var  logic              secondary_pd,
   output var  logic [1:0]        secondary_format,
   output var  logic              auxiliary_pd,
   output var  logic [1:0]        auxiliary_format,
   // switchover
   output var  logic              switch_immediate,
   output var  logic              fractional_loop_mux_sel,
   // frequency monitor
   output var  logic              monitor_enable,
   output var  logic              monitored_freq_19m44,
   output var  logic [2:0]        monitor_ref_code,
   output var  logic [1:0]        error_window,
   // interrupt
   output var  logic              irq
);
   // ==================================================
   // registers and nets
   logic [7:0]  chip_mode_control;
   logic [7:0]  input_receiver_config_a;
   logic [7:0]  input_receiver_config_b;
   logic [7:0]  switchover_control;
   logic [7:0]  frequency_monitor_config;
   logic [7:0]  irq_status;
   logic [7:0]  irq_mask;
   logic [1:0]  active_status;
   logic        pin_sel;
   logic [1:0]  pri_v;
   logic [1:0]  sec_v;
   logic        requested_sel;
   logic        next_mux_sel;
   logic [1:0]  next_status;
   logic        wr_fire;
   logic        rd_fire;
   logic        access;
   logic [9:0]  widx;
   logic        mapped;
   logic [7:0]  rd_value;
   logic [7:0]  ev_set;
   mon_freq_t   mon_freq;

   // ==================================================
   // synchronisers for external inputs
   sync_stage #(.WIDTH(5)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({ref_sel_pin, primary_verdict, secondary_verdict}),
      .sync_out ({pin_sel, pri_v, sec_v})
   );

   // ==================================================
   // apb decode
   // one wait state so read data comes from a flop
   assign access  = psel && penable;
   assign wr_fire = access && pready && pwrite;
   assign rd_fire = access && pready && !pwrite;
   assign widx    = paddr[ADDR_W-1:2];

   always_comb begin
      mapped   = 1'b1;
      rd_value = 8'h00;
      if (paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end else begin
         case (widx)
            IDX_CHIP_MODE:  rd_value = chip_mode_control;
            IDX_RX_CFG_A:   rd_value = input_receiver_config_a;
            IDX_RX_CFG_B:   rd_value = input_receiver_config_b;
            IDX_SWITCHOVER: rd_value = switchover_control;
            IDX_MON_CFG:    rd_value = frequency_monitor_config;
            IDX_REF_STATUS: begin
               rd_value[B_REF_STAT+:2]  = active_status;
               rd_value[B_ACTIVE_REF]   = fractional_loop_mux_sel;
            end
            IDX_IRQ_STATUS: rd_value = irq_status;
            IDX_IRQ_MASK:   rd_value = irq_mask;
            default:        mapped   = 1'b0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= access && !pready;
         pslverr <= access && !pready && !mapped;
         if (access && !pready) begin
            prdata <= {24'h000000, rd_value};
         end
      end
   end

   // ==================================================
   // configuration registers
   // stored through the mask so reserved bits never hold a one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chip_mode_control        <= RST_CHIP_MODE;
         input_receiver_config_a  <= RST_RX_CFG_A;
         input_receiver_config_b  <= RST_RX_CFG_B;
         switchover_control       <= RST_SWITCHOVER;
         frequency_monitor_config <= RST_MON_CFG;
         irq_mask                 <= RST_IRQ;
      end else if (wr_fire && mapped) begin
         case (widx)
            IDX_CHIP_MODE:
               chip_mode_control <= pwdata[7:0] & MASK_CHIP_MODE;
            IDX_RX_CFG_A:
               input_receiver_config_a <= pwdata[7:0] & MASK_RX_CFG_A;
            IDX_RX_CFG_B:
               input_receiver_config_b <= pwdata[7:0] & MASK_RX_CFG_B;
            IDX_SWITCHOVER:
               switchover_control <= pwdata[7:0] & MASK_SWITCHOVER;
            IDX_MON_CFG:
               frequency_monitor_config <= pwdata[7:0] & MASK_MON_CFG;
            IDX_IRQ_MASK:
               irq_mask <= pwdata[7:0] & MASK_IRQ;
            default: begin
            end
         endcase
      end
   end

   // ==================================================
   // configuration outputs
   assign chip_power_down      = chip_mode_control[B_CHIP_PD];
   assign integer_loop_ref_aux = chip_mode_control[B_INT_REF_SEL];
   assign primary_pd           = input_receiver_config_a[B_PRI_PD];
   assign primary_format       = input_receiver_config_a[B_PRI_FMT+:2];
   assign secondary_pd         = input_receiver_config_a[B_SEC_PD];
   assign secondary_format     = input_receiver_config_a[B_SEC_FMT+:2];
   assign auxiliary_pd         = input_receiver_config_b[B_AUX_PD];
   assign auxiliary_format     = input_receiver_config_b[B_AUX_FMT+:2];
   assign switch_immediate     = switchover_control[B_IMMEDIATE];
   assign monitor_enable       = frequency_monitor_config[B_MON_EN];
   assign mon_freq             = mon_freq_t'(frequency_monitor_config[B_MON_FREQ]);
   assign monitored_freq_19m44 = (mon_freq == MON_19M44);
   assign error_window         = frequency_monitor_config[B_ERR_WIN+:2];

   // effective reference code; 8 kHz wins over the carrier field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         monitor_ref_code <= 3'h0;
      end else if (frequency_monitor_config[B_MON_8K]) begin
         monitor_ref_code <= MREF_8K;
      end else begin
         monitor_ref_code <= {1'b0, frequency_monitor_config[B_CARRIER+:2]};
      end
   end

   // ==================================================
   // reference selection
   always_comb begin
      if (switchover_control[B_SOFT_EN]) begin
         requested_sel = switchover_control[B_SOFT_SEL];
      end else begin
         requested_sel = pin_sel;
      end
   end

   // redundancy only leaves a failing input for a healthy one;
   // with both bad it stays put rather than bounce.
   // relies on software having set up monitor and crystals first.
   always_comb begin
      next_mux_sel = fractional_loop_mux_sel;
      if (switchover_control[B_REDUNDANT]) begin
         if (monitor_enable) begin
            if (!fractional_loop_mux_sel && pri_v != ST_VALID
                && sec_v == ST_VALID) begin
               next_mux_sel = 1'b1;
            end else if (fractional_loop_mux_sel && sec_v != ST_VALID
                         && pri_v == ST_VALID) begin
               next_mux_sel = 1'b0;
            end
         end
      end else begin
         next_mux_sel = requested_sel;
      end
   end

   always_comb begin
      if (monitor_enable) begin
         next_status = fractional_loop_mux_sel ? sec_v : pri_v;
      end else if (requested_sel == fractional_loop_mux_sel) begin
         next_status = ST_AGREE;
      end else begin
         next_status = ST_DISAGREE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fractional_loop_mux_sel <= 1'b0;
         active_status           <= ST_VALID;
      end else begin
         fractional_loop_mux_sel <= next_mux_sel;
         active_status           <= next_status;
      end
   end

   // ==================================================
   // interrupt status, cleared by read; a new event beats the clear
   always_comb begin
      ev_set              = 8'h00;
      ev_set[B_EV_SWITCH] = next_mux_sel != fractional_loop_mux_sel;
      ev_set[B_EV_FAULT]  = monitor_enable && next_status != ST_VALID
                            && active_status == ST_VALID;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= RST_IRQ;
      end else if (rd_fire && mapped && widx == IDX_IRQ_STATUS) begin
         // clear only what the read returned; later events survive
         irq_status <= (irq_status & ~prdata[7:0]) | ev_set;
      end else begin
         irq_status <= irq_status | ev_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end
endmodule
`default_nettype wire

/* File: tb/refsw_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module refsw_checker
   import refsw_pkg::*;
(
   // apb side
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // configuration outputs
   input wire logic              chip_power_down,
   input wire logic              primary_pd,
   input wire logic [1:0]        primary_format,
   input wire logic              secondary_pd,
   input wire logic              monitor_enable,
   input wire logic [1:0]        error_window,
   input wire logic              irq
);
   // ==================================================
   // helpers
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_ok;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;

   // ==================================================
   // assertions
   chk_reset_pd: assert property ($rose(presetn) |-> chip_power_down)
      else $error("chip not powered down after reset");
   chk_one_wait: assert property (
      psel && $rose(penable) |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_chip_write: assert property (
      wr_ok && paddr == 12'h100 |=> chip_power_down == $past(pwdata[1]))
      else $error("chip power-down not written");
   chk_rx_write: assert property (
      wr_ok && paddr == 12'h200 |=> primary_format == $past(pwdata[1:0])
      && primary_pd == $past(pwdata[2]) && secondary_pd == $past(pwdata[6]))
      else $error("receiver config not written");
   chk_mon_write: assert property (
      wr_ok && paddr == 12'h20c |=> monitor_enable == $past(pwdata[7])
      && error_window == $past(pwdata[1:0]))
      else $error("monitor config not written");
   chk_misalign_err: assert property (
      pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
      else $error("misaligned access not refused");
   chk_reserved_zero: assert property (
      pready && !pwrite && paddr == 12'h208 |-> prdata[31:4] == 28'h0)
      else $error("reserved switchover bits not zero");
   cover property (wr_ok && paddr == 12'h208);
   cover property (pready && pslverr);
   cover property ($rose(irq));
endmodule
bind reference_input_switchover_ctrl refsw_checker refsw_checker_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .chip_power_down, .primary_pd, .primary_format,
   .secondary_pd, .monitor_enable, .error_window, .irq);
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
   import refsw_pkg::*;
;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic              ref_sel_pin, chip_power_down, integer_loop_ref_aux;
   logic              primary_pd, secondary_pd, auxiliary_pd, irq;
   logic              switch_immediate, fractional_loop_mux_sel;
   logic              monitor_enable, monitored_freq_19m44, err;
   logic [1:0]        primary_verdict, secondary_verdict, error_window;
   logic [1:0]        primary_format, secondary_format, auxiliary_format;
   logic [2:0]        monitor_ref_code;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd, v;
   logic [7:0]        sh [5];
   logic [11:0]       regs [5] = '{12'h100, 12'h200, 12'h204, 12'h208, 12'h20c};
   int                n_mismatch, checks, seed;

   reference_input_switchover_ctrl reference_input_switchover_ctrl_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ref_sel_pin, .primary_verdict, .secondary_verdict,
      .chip_power_down, .integer_loop_ref_aux, .primary_pd, .primary_format,
      .secondary_pd, .secondary_format, .auxiliary_pd, .auxiliary_format,
      .switch_immediate, .fractional_loop_mux_sel, .monitor_enable,
      .monitored_freq_19m44, .monitor_ref_code, .error_window, .irq);

   // ==================================================
   // helpers
   function automatic logic [7:0] mask_of(input int i);
      logic [7:0] m [5] = '{MASK_CHIP_MODE, MASK_RX_CFG_A, MASK_RX_CFG_B,
                            MASK_SWITCHOVER, MASK_MON_CFG};
      return m[i];
   endfunction
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   // master holds everything until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         n_mismatch++;
         test_done();
      end
      @(posedge pclk);
   endtask
   task automatic outs();
      chk("outs", {sh[0][1:0], sh[1][6:0], sh[2][2:0], sh[3][3], sh[4][7],
         sh[4][5], sh[4][4] ? MREF_8K : {1'b0, sh[4][3:2]}, sh[4][1:0]},
         {chip_power_down, integer_loop_ref_aux, secondary_pd,
         secondary_format, 1'b0, primary_pd, primary_format, auxiliary_pd,
         auxiliary_format, switch_immediate, monitor_enable,
         monitored_freq_19m44, monitor_ref_code,
         error_window});
   endtask

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ==================================================
   // main sequence
   initial begin
      seed = 88;
      {presetn, psel, penable, pwrite, ref_sel_pin} = 5'h0;
      {paddr, pwdata, primary_verdict, secondary_verdict} = '0;
      sh = '{RST_CHIP_MODE, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, regs[i], 32'h0);
         chk("reset value", {24'h0, sh[i]}, rd);
      end
      outs();
      $display("test reset done");
      // random writes, upper and reserved bits included
      for (int k = 0; k < 40; k++) begin
         v = $random(seed);
         if (k % 5 == 3) v[2] = 1'b0;
         apb(1'b1, regs[k % 5], v);
         sh[k % 5] = v[7:0] & mask_of(k % 5);
         apb(1'b0, regs[k % 5], 32'h0);
         chk("readback", {24'h0, sh[k % 5]}, rd);
         outs();
      end
      apb(1'b1, 12'h101, 32'h0);
      chk("misaligned err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h104, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h100, 32'h0);
      chk("chip kept", {24'h0, sh[0]}, rd);
      $display("test random done");
      // soft select versus pin, and the active input indicator
      for (int k = 0; k < 4; k++) begin
         ref_sel_pin <= k[0];
         apb(1'b1, 12'h208, {28'h0, 2'h0, ~k[1], k[0] ^ k[1]});
         repeat (4) @(posedge pclk);
         chk("mux sel", {31'h0, k[0]},
             {31'h0, fractional_loop_mux_sel});
         apb(1'b0, 12'h084, 32'h0);
         chk("active ref", {28'h0, k[0], 3'h0}, rd);
      end
      $display("test select done");
      // redundancy switchover with interrupt, masked and unmasked
      // pin back to primary so the switchover starts from primary
      ref_sel_pin <= 1'b0;
      apb(1'b1, 12'h3c4, 32'h3);
      apb(1'b1, 12'h200, 32'h22);
      apb(1'b1, 12'h20c, 32'h80);
      apb(1'b0, 12'h3c0, 32'h0);
      apb(1'b1, 12'h208, 32'h4);
      primary_verdict <= ST_SLOW;
      repeat (10) @(posedge pclk);
      chk("auto to secondary", 32'h1,
          {31'h0, fractional_loop_mux_sel});
      chk("irq set", 32'h1, {31'h0, irq});
      apb(1'b0, 12'h3c0, 32'h0);
      chk("irq status", 32'h3, rd);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b0, 12'h084, 32'h0);
      chk("ref status", 32'h8, rd);
      apb(1'b1, 12'h3c4, 32'h0);
      primary_verdict <= ST_VALID;
      secondary_verdict <= ST_FAST;
      repeat (10) @(posedge pclk);
      chk("auto to primary", 32'h0,
          {31'h0, fractional_loop_mux_sel});
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b0, 12'h3c0, 32'h0);
      chk("irq status masked", 32'h3, rd);
      $display("test redundancy done");
      test_done();
   end
endmodule
`default_nettype wire
